// ---- rtl/dsp_core_run_control.sv ----
// Run control registers: frame trigger select, launch, abort, entry point.
//
// What this block does
// (R1) Codes 0 to 4 pick clock generator 1 at quarter to four times base.
// (R2) Codes 5 to 7 pick clock generator 2 at base/6, base/3, 2/3 base.
// (R3) Codes 8 to 11 follow serial input ports 0 to 3 frame rate.
// (R4) Codes 12 to 15 follow serial output ports 0 to 3 frame rate.
// (R5) Code 16 follows the rate recovered from the S/PDIF receiver.
// (R6) Trigger select field is five bits, resets to 2, upper bits reserved.
// (R7) Rising launch bit enables the core and starts the program counter.
// (R8) A launched program counter steps through program memory in order.
// (R9) Falling launch bit leaves core execution untouched.
// (R10) Rising abort bit halts the core at once, mid frame.
// (R11) Falling abort bit has no effect on the core.
// (R12) Software uses abort only for debug, preferring the dormant request.
// (R13) Launch loads the program counter from the entry point, reset zero.
// (R14) Dormant request stops the core only after the current frame ends.
// (R15) Dormant request masks interrupts and sleeps; clearing it unmasks.
// (R16) Status reads 000 after boot or abort, 001 while running.
// (R17) The selected trigger pulse starts each audio frame.
// (R18) Edges are found by comparing written bit with stored bit.
// (R19) Abort wins over launch when both arrive together.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module dsp_core_run_control
  import run_ctrl_pkg::*;
(
  input wire logic clk_sys, // System clock, 20 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [REG_AW-1:0] reg_addr, // Register address.
  input wire logic [REG_DW-1:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [REG_DW-1:0] reg_rdata, // Read data, cycle after strobe.
  input wire logic [4:0] cg1_tick, // Clock generator 1 frame levels.
  input wire logic [2:0] cg2_tick, // Clock generator 2 frame levels.
  input wire logic [3:0] sin_frame, // Serial input port frame clocks.
  input wire logic [3:0] sout_frame, // Serial output port frame clocks.
  input wire logic spdif_frame, // Receiver recovered frame clock.
  output logic core_enable, // Core clock enable, high only while active, low when stopped or asleep.
  output logic [REG_DW-1:0] prog_counter, // Program fetch address.
  output logic [STATUS_W-1:0] core_status, // Run state code.
  output logic irq_mask, // High masks all core interrupts.
  output logic frame_start // One-cycle start of audio frame.
);

  ////////////////////////////////////////////////////////////////////////////
  // State and reset image.

  typedef struct packed {
    logic dormant;
    logic [SEL_W-1:0] sel;
    logic launch;
    logic abort;
    logic [REG_DW-1:0] entry;
    run_state_t run;
    logic en;
    logic [REG_DW-1:0] pc;
    logic [REG_DW-1:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t RESET_STATE = '{
    dormant: RST_DORMANT,
    sel: RST_FRAME_SEL,
    launch: RST_TRIGGER_BIT,
    abort: RST_TRIGGER_BIT,
    entry: RST_ENTRY,
    run: RUN_STOP,
    en: 1'b0,
    pc: RST_ENTRY,
    rdata: 16'h0000
  };

  ctrl_state_t q;
  ctrl_state_t n;
  logic launch_rise;
  logic abort_rise;
  logic [SRC_N-1:0] src;

  trig_if trig ();

  // Decode shared by the write and the read path.
  function automatic logic hit(input logic [REG_AW-1:0] a,
                               input logic [REG_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Frame trigger selection.

  // Source index equals the select code, so the packing order matters.
  assign src = {spdif_frame, sout_frame, sin_frame, cg2_tick, cg1_tick};
  assign trig.sel = q.sel;

  frame_trigger_mux #(
    .N(SRC_N)
  ) u_mux (
    .clk_sys(clk_sys),
    .rst(rst),
    .src(src),
    .trig(trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register access and run sequencing.

  always_comb
  begin
    n = q;
    n.rdata = 16'h0000;
    launch_rise = 1'b0;
    abort_rise = 1'b0;

    if (reg_wr)
    begin
      if (hit(reg_addr, OFS_DORMANT))
      begin
        n.dormant = reg_wdata[BIT_TRIGGER]; // [R15]
      end
      else if (hit(reg_addr, OFS_FRAME_SEL))
      begin
        n.sel = reg_wdata[SEL_W-1:0]; // [R6]
      end
      else if (hit(reg_addr, OFS_LAUNCH))
      begin
        n.launch = reg_wdata[BIT_TRIGGER];
        launch_rise = reg_wdata[BIT_TRIGGER] & ~q.launch; // [R18] [R7] [R9]
      end
      else if (hit(reg_addr, OFS_ABORT))
      begin
        n.abort = reg_wdata[BIT_TRIGGER];
        abort_rise = reg_wdata[BIT_TRIGGER] & ~q.abort; // [R18] [R10] [R11]
      end
      else if (hit(reg_addr, OFS_ENTRY))
      begin
        n.entry = reg_wdata;
      end
    end

    // Reserved bits read as zero; unmapped reads return zero.
    if (reg_rd)
    begin
      if (hit(reg_addr, OFS_DORMANT))
      begin
        n.rdata = {15'h0000, q.dormant};
      end
      else if (hit(reg_addr, OFS_FRAME_SEL))
      begin
        n.rdata = {11'h000, q.sel}; // [R6]
      end
      else if (hit(reg_addr, OFS_LAUNCH))
      begin
        n.rdata = {15'h0000, q.launch};
      end
      else if (hit(reg_addr, OFS_ABORT))
      begin
        n.rdata = {15'h0000, q.abort};
      end
      else if (hit(reg_addr, OFS_ENTRY))
      begin
        n.rdata = q.entry;
      end
      else if (hit(reg_addr, OFS_STATUS))
      begin
        n.rdata = {13'h0000, q.run}; // [R16]
      end
    end

    // Abort is checked first so that it can never lose to a launch.
    if (abort_rise)
    begin
      n.run = RUN_STOP; // [R10] [R19] [R16]
    end
    else if (launch_rise)
    begin
      n.run = RUN_ACTIVE; // [R7] [R16]
      n.pc = q.entry; // [R13]
    end
    else
    begin
      case (q.run)
        RUN_ACTIVE:
        begin
          if (trig.frame_start)
          begin
            // A new frame either rewinds the program or lets the core sleep.
            if (q.dormant)
            begin
              n.run = RUN_SLEEP; // [R14] [R15]
            end
            else
            begin
              n.pc = q.entry; // [R17]
            end
          end
          else
          begin
            n.pc = q.pc + 16'h0001; // [R8]
          end
        end
        RUN_SLEEP:
        begin
          // Waking waits for a frame edge so that the program starts clean.
          if (!q.dormant && trig.frame_start)
          begin
            n.run = RUN_ACTIVE; // [R15] [R17]
            n.pc = q.entry;
          end
        end
        default:
        begin
          n.run = RUN_STOP;
        end
      endcase
    end

    n.en = (n.run == RUN_ACTIVE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= RESET_STATE; // [R6] [R16]
    end
    else
    begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign core_enable = q.en;
  assign prog_counter = q.pc;
  assign core_status = q.run;
  assign irq_mask = q.dormant; // [R15]
  assign frame_start = trig.frame_start;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence launch_wr_s;
    reg_wr && hit(reg_addr, OFS_LAUNCH) && reg_wdata[BIT_TRIGGER];
  endsequence

  sequence launch_fall_s;
    reg_wr && hit(reg_addr, OFS_LAUNCH) && !reg_wdata[BIT_TRIGGER]
      && q.launch;
  endsequence

  sequence abort_rise_s;
    reg_wr && hit(reg_addr, OFS_ABORT) && reg_wdata[BIT_TRIGGER]
      && !q.abort;
  endsequence

  sequence abort_fall_s;
    reg_wr && hit(reg_addr, OFS_ABORT) && !reg_wdata[BIT_TRIGGER]
      && q.abort;
  endsequence

  sequence quiet_frame_s;
    !trig.frame_start;
  endsequence

  launch_start_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    launch_wr_s ##0 !q.launch |=> q.run == RUN_ACTIVE && q.en
      && q.pc == $past(q.entry)) // [R13]
    else $error("launch edge did not start at the entry point");

  launch_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    launch_wr_s ##0 q.launch ##0 q.run == RUN_STOP |=> q.run == RUN_STOP)
    else $error("rewriting a set launch bit restarted the core");

  launch_fall_a: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
    launch_fall_s ##0 quiet_frame_s |=> q.run == $past(q.run))
    else $error("falling launch bit changed the run state");

  abort_halt_a: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    abort_rise_s |=> q.run == RUN_STOP && !q.en ##1 q.run == RUN_STOP
      || q.launch != $past(q.launch))
    else $error("abort edge did not halt the core");

  abort_fall_a: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
    abort_fall_s ##0 quiet_frame_s |=> q.run == $past(q.run))
    else $error("falling abort bit changed the run state");

  pc_step_a: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    q.run == RUN_ACTIVE && !trig.frame_start && !launch_rise && !abort_rise
      |=> q.pc == $past(q.pc) + 16'h0001)
    else $error("program counter did not advance by one");

  dormant_wait_a: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
    q.dormant && q.run == RUN_ACTIVE && !trig.frame_start && !launch_rise
      && !abort_rise |=> q.run == RUN_ACTIVE)
    else $error("dormant request stopped the core mid frame");

  dormant_sleep_a: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
    q.dormant && q.run == RUN_ACTIVE && trig.frame_start && !launch_rise
      && !abort_rise |=> q.run == RUN_SLEEP && irq_mask && !core_enable)
    else $error("dormant request did not sleep at frame end");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
    reg_wr && hit(reg_addr, OFS_DORMANT) |=> irq_mask == $past(reg_wdata[0]))
    else $error("interrupt mask does not follow the dormant request");

  reset_image_a: assert property (@(posedge clk_sys) // [R6]
    rst |=> q.sel == RST_FRAME_SEL && q.run == RUN_STOP
      && q.entry == RST_ENTRY && !core_enable) // [R16]
    else $error("reset values are wrong");

  status_read_a: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
    reg_rd && hit(reg_addr, OFS_STATUS) |=> reg_rdata == {13'h0000,
      $past(q.run)} ##1 reg_rdata == 16'h0000 || $past(reg_rd))
    else $error("status read back is wrong");

  sel_read_a: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    reg_rd && hit(reg_addr, OFS_FRAME_SEL) |=> reg_rdata[15:5] == 11'h000
      && reg_rdata[4:0] == $past(q.sel))
    else $error("trigger select read back is wrong");

endmodule : dsp_core_run_control

// ---- shared/run_ctrl_pkg.sv ----
// Shared constants and types for the core run control registers.
package run_ctrl_pkg;

  localparam int REG_AW = 16;
  localparam int REG_DW = 16;
  localparam int SEL_W = 5;
  localparam int STATUS_W = 3;
  localparam int SRC_N = 17;

  localparam logic [REG_AW-1:0] OFS_DORMANT = 16'hf400;
  localparam logic [REG_AW-1:0] OFS_FRAME_SEL = 16'hf401;
  localparam logic [REG_AW-1:0] OFS_LAUNCH = 16'hf402;
  localparam logic [REG_AW-1:0] OFS_ABORT = 16'hf403;
  localparam logic [REG_AW-1:0] OFS_ENTRY = 16'hf404;
  localparam logic [REG_AW-1:0] OFS_STATUS = 16'hf405;

  localparam int BIT_TRIGGER = 0;

  localparam logic [SEL_W-1:0] RST_FRAME_SEL = 5'h02;
  localparam logic [REG_DW-1:0] RST_ENTRY = 16'h0000;
  localparam logic RST_TRIGGER_BIT = 1'b0;
  localparam logic RST_DORMANT = 1'b0;

  // Select codes equal the bit index into the packed source vector.
  localparam logic [SEL_W-1:0] SEL_CG1_BASE = 5'h00;
  localparam logic [SEL_W-1:0] SEL_CG2_BASE = 5'h05;
  localparam logic [SEL_W-1:0] SEL_SIN_BASE = 5'h08;
  localparam logic [SEL_W-1:0] SEL_SOUT_BASE = 5'h0c;
  localparam logic [SEL_W-1:0] SEL_SPDIF = 5'h10;

  typedef enum logic [STATUS_W-1:0] {
    RUN_STOP = 3'b000,
    RUN_ACTIVE = 3'b001,
    RUN_SLEEP = 3'b011
  } run_state_t;

endpackage : run_ctrl_pkg

// ---- shared/trig_if.sv ----
// Carrier between the run controller and the frame trigger selector.
`timescale 1ns/10ps
interface trig_if;
  import run_ctrl_pkg::*;
  logic [SEL_W-1:0] sel;
  logic frame_start;
  modport ctrl (output sel, input frame_start);
  modport mux (input sel, output frame_start);
endinterface : trig_if

// ---- rtl/frame_trigger_mux.sv ----
// Synchronises the frame sources and picks the one that starts each frame.
`timescale 1ns/10ps
module frame_trigger_mux
  import run_ctrl_pkg::*;
#(
  parameter int N = SRC_N
)
(
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [N-1:0] src, // Raw frame rate levels.
  trig_if.mux trig // Select in, frame pulse out.
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic prev;
    logic pulse;
  } mux_state_t;

  mux_state_t q;
  mux_state_t n;
  logic lvl;

  // Codes with no source behind them never start a frame.
  function automatic logic pick(input logic [N-1:0] v,
                                input logic [SEL_W-1:0] s);
    pick = 1'b0;
    if (int'(s) < N)
    begin
      pick = v[s];
    end
  endfunction : pick

  always_comb
  begin
    n = q;
    n.s1 = src;
    n.s2 = q.s1;
    lvl = pick(q.s2, trig.sel); // [R1] [R2] [R3] [R4] [R5]
    n.prev = lvl;
    n.pulse = lvl & ~q.prev; // [R17]
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign trig.frame_start = q.pulse;

  pulse_origin_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.pulse |-> $past(lvl) && !$past(q.prev)) // [R17]
    else $error("frame pulse without a rising selected source");

endmodule : frame_trigger_mux

// ---- tb/testbench.sv ----
// Self-checking testbench for the core run control registers.
`timescale 1ns/10ps
module testbench;
  import run_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [SRC_N-1:0] src = '0;
  logic [REG_DW-1:0] reg_rdata;
  logic core_enable;
  logic [REG_DW-1:0] prog_counter;
  logic [STATUS_W-1:0] core_status;
  logic irq_mask;
  logic frame_start;
  logic [15:0] pc_ref;
  int error_cnt = 0;
  int check_count = 0;
  bit hit;
  localparam logic [15:0] ENTRY = 16'ha5c3;

  always #25 clk_sys = ~clk_sys;

  dsp_core_run_control dsp_core_run_control_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cg1_tick(src[4:0]),
    .cg2_tick(src[7:5]),
    .sin_frame(src[11:8]),
    .sout_frame(src[15:12]),
    .spdif_frame(src[16]),
    .core_enable(core_enable),
    .prog_counter(prog_counter),
    .core_status(core_status),
    .irq_mask(irq_mask),
    .frame_start(frame_start)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  // Read data is only valid in the single cycle after the strobe.
  task automatic read_check(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : read_check

  task automatic wait_frame(output bit h);
    h = 1'b0;
    repeat (8)
    begin
      @(posedge clk_sys);
      #1;
      if (frame_start === 1'b1)
        h = 1'b1;
      if (h)
        break;
    end
  endtask : wait_frame

  // Returns one cycle after the frame pulse, the source left high.
  // The bit is set through a mask so that no automatic index is written.
  task automatic pulse(input int idx, output bit h);
    @(posedge clk_sys);
    src <= src | (SRC_N'(1) << idx);
    wait_frame(h);
    @(posedge clk_sys);
    #1;
    check(16'(frame_start), 16'h0000);
  endtask : pulse

  // Dropping all sources and idling lets the synchronisers drain.
  task automatic settle();
    @(posedge clk_sys);
    src <= '0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1ms;
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    read_check(OFS_FRAME_SEL, 16'h0002);
    read_check(OFS_LAUNCH, 16'h0000);
    read_check(OFS_ABORT, 16'h0000);
    read_check(OFS_ENTRY, 16'h0000);
    read_check(OFS_STATUS, 16'h0000);
    read_check(OFS_DORMANT, 16'h0000);
    read_check(16'hf406, 16'h0000);
    reg_write(OFS_STATUS, 16'hffff);
    read_check(OFS_STATUS, 16'h0000);
    // Every defined code: others toggling stay silent, own source pulses.
    for (int c = 0; c < SRC_N; c++)
    begin
      reg_write(OFS_FRAME_SEL, 16'(c));
      @(posedge clk_sys);
      src <= ~(SRC_N'(1) << c);
      wait_frame(hit);
      check(16'(hit), 16'h0000);
      settle();
      pulse(c, hit);
      check(16'(hit), 16'h0001);
      settle();
    end
    reg_write(OFS_FRAME_SEL, 16'hffff);
    read_check(OFS_FRAME_SEL, 16'h001f);
    @(posedge clk_sys);
    src <= '1;
    wait_frame(hit);
    check(16'(hit), 16'h0000);
    settle();
    reg_write(OFS_FRAME_SEL, 16'h0002);
    reg_write(OFS_ENTRY, ENTRY);
    read_check(OFS_ENTRY, ENTRY);
    // Launch, then rewrite one and zero while the counter runs on.
    reg_write(OFS_LAUNCH, 16'h0001);
    check(16'(core_status), 16'h0001);
    check(16'(core_enable), 16'h0001);
    check(prog_counter, ENTRY);
    @(posedge clk_sys);
    #1;
    check(prog_counter, ENTRY + 16'h0001);
    reg_write(OFS_LAUNCH, 16'h0001);
    check(prog_counter, ENTRY + 16'h0003);
    reg_write(OFS_LAUNCH, 16'h0000);
    check(prog_counter, ENTRY + 16'h0005);
    check(16'(core_status), 16'h0001);
    pulse(2, hit);
    check(prog_counter, ENTRY);
    settle();
    // Dormant request waits for the frame boundary before sleeping.
    reg_write(OFS_DORMANT, 16'h0001);
    check(16'(irq_mask), 16'h0001);
    check(16'(core_status), 16'h0001);
    pulse(2, hit);
    check(16'(core_status), 16'h0003);
    check(16'(core_enable), 16'h0000);
    settle();
    reg_write(OFS_DORMANT, 16'h0000);
    check(16'(irq_mask), 16'h0000);
    check(16'(core_status), 16'h0003);
    pulse(2, hit);
    check(16'(core_status), 16'h0001);
    check(prog_counter, ENTRY);
    settle();
    // Abort mid-frame freezes the counter; its falling edge is inert.
    reg_write(OFS_ABORT, 16'h0001);
    check(16'(core_status), 16'h0000);
    check(16'(core_enable), 16'h0000);
    pc_ref = prog_counter;
    @(posedge clk_sys);
    #1;
    check(prog_counter, pc_ref);
    reg_write(OFS_ABORT, 16'h0000);
    check(16'(core_status), 16'h0000);
    read_check(OFS_ABORT, 16'h0000);
    pulse(2, hit);
    check(16'(core_status), 16'h0000);
    settle();
    reg_write(OFS_LAUNCH, 16'h0001);
    check(prog_counter, ENTRY);
    read_check(OFS_STATUS, 16'h0001);
    reg_write(OFS_ABORT, 16'h0001);
    read_check(OFS_STATUS, 16'h0000);
    // Rewriting a launch bit that is already set must not restart the core.
    reg_write(OFS_LAUNCH, 16'h0001);
    check(16'(core_status), 16'h0000);
    check(16'(core_enable), 16'h0000);
    read_check(OFS_LAUNCH, 16'h0001);
    final_report();
  end
endmodule : testbench
